// [dsr_host_model.sv]
// host controller model on the parallel and serial pins
module dsr_host_model (
	input  wire         clk_in,
	input  wire  [7:0]  rdata_in,
	input  wire         oe_in,
	input  wire         sdo_in,
	input  wire         sdo_oe_in,
	output logic        sel_out,
	output logic        wr_out,
	output logic        rd_out,
	output logic [17:0] data_out,
	output logic        mode_out,
	output logic        cs_n_out,
	output logic        sclk_out,
	output logic        sdin_out
);
	timeunit 1ns;
	timeprecision 100ps;
	// idle levels: strobes and chip select high, serial clock low
	initial begin
		sel_out  = 1'b1;
		wr_out   = 1'b1;
		rd_out   = 1'b1;
		data_out = 18'h3FFFF;
		mode_out = 1'b0;
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdin_out = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#2;
	endtask
	task automatic wr_cmd(input logic [7:0] op);
		sel_out = 1'b0;
		data_out = {10'h2A5, op};
		wr_out = 1'b0;
		tick(4);
		wr_out = 1'b1;
		tick(4);
		data_out = ~data_out;
		sel_out = 1'b1;
		tick(4);
	endtask
	task automatic rd_par(output logic [7:0] v, output logic oe);
		rd_out = 1'b0;
		tick(4);
		v = rdata_in;
		oe = oe_in;
		rd_out = 1'b1;
		tick(4);
	endtask
	// dummy word first, status byte second
	task automatic readback(input logic [7:0] op, output logic [7:0] d, output logic [7:0] v, output logic oe);
		wr_cmd(op);
		rd_par(d, oe);
		rd_par(v, oe);
	endtask
	task automatic ser_read(input logic [7:0] op, output logic [7:0] v, output logic oe);
		mode_out = 1'b1;
		tick(4);
		cs_n_out = 1'b0;
		sel_out = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			sdin_out = op[i];
			tick(4);
			sclk_out = 1'b1;
			tick(4);
			sclk_out = 1'b0;
		end
		sel_out = 1'b1;
		sdin_out = ~sdin_out;
		tick(4);
		sclk_out = 1'b1;
		tick(4);
		oe = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			sclk_out = 1'b0;
			tick(4);
			v[i] = sdo_in;
			oe = oe & sdo_oe_in;
			sclk_out = 1'b1;
			tick(4);
		end
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		tick(4);
		mode_out = 1'b0;
		tick(4);
	endtask
endmodule

// [dsr_map.vh]
// opcodes, field positions and reset values of the status readback block
`ifndef DSR_MAP_VH
`define DSR_MAP_VH

// readback opcodes
`define DSR_OP_POWER_STATE     8'h0A
`define DSR_OP_ADDRESS_ORDER   8'h0B
`define DSR_OP_PIXEL_FORMAT    8'h0C

// power-mode byte bit positions
`define DSR_PM_BOOSTER         7
`define DSR_PM_IDLE            6
`define DSR_PM_PARTIAL         5
`define DSR_PM_AWAKE           4
`define DSR_PM_FULL_SCREEN     3
`define DSR_PM_PANEL_ON        2

// memory access control field positions
`define DSR_MAC_ROW_DIR        7
`define DSR_MAC_COL_DIR        6
`define DSR_MAC_SWAP           5
`define DSR_MAC_VREFRESH       4
`define DSR_MAC_BGR            3
`define DSR_MAC_HREFRESH       2

// reset values and the dummy byte
`define DSR_MAC_RESET          8'h00
`define DSR_PIXFMT_RESET       3'h6
`define DSR_DUMMY_BYTE         8'h00

// pixel format codes
`define DSR_PIXFMT_12BPP       3'h3
`define DSR_PIXFMT_16BPP       3'h5
`define DSR_PIXFMT_18BPP       3'h6
`define DSR_PIXFMT_UNUSED      3'h7

// synchroniser lanes: [15:8] data, 7 hw reset, 6 select, 5 wr, 4 rd, 3 cs, 2 sclk, 1 sdin, 0 mode
`define DSR_SYNC_W             16
`define DSR_SYNC_IDLE          16'h00F8
`define DSR_LANE_HWRST         7
`define DSR_LANE_SEL           6
`define DSR_LANE_WR            5
`define DSR_LANE_RD            4
`define DSR_LANE_CS            3
`define DSR_LANE_SCLK          2
`define DSR_LANE_SDIN          1
`define DSR_LANE_MODE          0

// serial read phase: one dummy clock then eight data clocks
`define DSR_SER_FIRST_BIT      4'h1
`define DSR_SER_LAST_BIT       4'h8
`define DSR_SER_OPCODE_LAST    3'h7

`endif

// [dsr_monitor.sv]
// concurrent checks on the status readback ports
module dsr_monitor (
	// clock and resets
	input wire       clk_in,
	input wire       rst_n_in,
	input wire       hw_reset_n_in,
	// host pins
	input wire       cmd_param_select_in,
	input wire       read_strobe_in,
	input wire       serial_mode_in,
	input wire       ser_cs_n_in,
	input wire       data_oe_out,
	input wire       ser_data_oe_out,
	// state updates and settings
	input wire       sw_reset_in,
	input wire       mac_write_in,
	input wire [7:0] mac_data_in,
	input wire       pixfmt_write_in,
	input wire [2:0] pixfmt_data_in,
	input wire [7:0] memory_access_control_out,
	input wire [2:0] host_pixel_format_code_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	a_oe_needs_read: assert property (data_oe_out |-> !$past(read_strobe_in, 3) && $past(cmd_param_select_in, 3) && !$past(serial_mode_in, 3)) else $error("parallel drive without read");
	a_ser_oe_frame: assert property (ser_data_oe_out |-> !$past(ser_cs_n_in, 3) && $past(serial_mode_in, 3)) else $error("serial drive outside frame");
	a_mac_hw_clear: assert property (!hw_reset_n_in [*4] |-> memory_access_control_out == 8'h00) else $error("hw reset left mac set");
	a_mac_load_write: assert property (hw_reset_n_in [*4] ##0 mac_write_in |=> memory_access_control_out == $past(mac_data_in)) else $error("mac not loaded");
	a_sw_keeps_mac: assert property (hw_reset_n_in [*4] ##0 (sw_reset_in && !mac_write_in) |=> $stable(memory_access_control_out)) else $error("sw reset changed mac");
	a_fmt_sw_reset: assert property (sw_reset_in |=> host_pixel_format_code_out == 3'h6) else $error("sw reset format wrong");
	a_fmt_load_write: assert property (pixfmt_write_in && !sw_reset_in |=> host_pixel_format_code_out == $past(pixfmt_data_in)) else $error("format not loaded");
	a_hw_keeps_fmt: assert property (!hw_reset_n_in && !sw_reset_in && !pixfmt_write_in |=> $stable(host_pixel_format_code_out)) else $error("hw reset changed format");
endmodule
bind dsr_top dsr_monitor u_mon (.clk_in, .rst_n_in, .hw_reset_n_in, .cmd_param_select_in, .read_strobe_in, .serial_mode_in,
	.ser_cs_n_in, .data_oe_out, .ser_data_oe_out, .sw_reset_in, .mac_write_in, .mac_data_in, .pixfmt_write_in,
	.pixfmt_data_in, .memory_access_control_out, .host_pixel_format_code_out);

// [dsr_top.v]
// status readback logic: power-mode, address-order and pixel-format readbacks
//
// Overview of operation
// - opcodes 0Ah, 0Bh, 0Ch select power, address-order and pixel-format bytes.
// - opcode taken with select low on write rise; reads select high; upper lanes ignored.
// - parallel reads return a dummy word first, status byte as second parameter.
// - power byte bit 7 shows the booster running.
// - power byte bit 6 shows idle reduced-colour operation active.
// - power byte bit 5 shows partial-area display active.
// - power byte bit 4 is 1 when awake, 0 in sleep.
// - power byte bit 3 is 1 for full-screen normal display.
// - power byte bit 2 shows panel output on; bits 1 and 0 zero.
// - address byte bit 7 mirrors memory access control bit 7, row direction.
// - address byte bit 6 mirrors memory access control bit 6, column direction.
// - address byte bit 5 shows row and column exchange.
// - address byte bit 4 shows vertical refresh direction.
// - address byte bit 3 shows blue-green-red subpixel order.
// - address byte bit 2 shows horizontal refresh direction; bits 1 and 0 zero.
// - address byte is 00h after power-on and hardware reset; software reset keeps it.
// - pixel byte has zero upper nibble and format code in bits 2 to 0.
// - serial reads insert one dummy clock before the first valid bit.
// - software reset sets pixel format to 18 bits; hardware reset keeps it.

`include "dsr_map.vh"

module dsr_top (
	// clock and power-on reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// hardware reset pin
	input  wire        hw_reset_n_in,
	// parallel host pins
	input  wire        cmd_param_select_in,
	input  wire        write_strobe_in,
	input  wire        read_strobe_in,
	input  wire [17:0] data_in,
	output reg  [7:0]  data_out,
	output reg         data_oe_out,
	// serial host pins
	input  wire        serial_mode_in,
	input  wire        ser_cs_n_in,
	input  wire        ser_clk_in,
	input  wire        ser_data_in,
	output reg         ser_data_out,
	output reg         ser_data_oe_out,
	// live internal state
	input  wire        booster_running_in,
	input  wire        idle_active_in,
	input  wire        partial_active_in,
	input  wire        awake_flag_in,
	input  wire        full_screen_flag_in,
	input  wire        panel_output_on_in,
	// state updates from the write-command side
	input  wire        sw_reset_in,
	input  wire        mac_write_in,
	input  wire [7:0]  mac_data_in,
	input  wire        pixfmt_write_in,
	input  wire [2:0]  pixfmt_data_in,
	// current settings
	output reg  [7:0]  memory_access_control_out,
	output reg  [2:0]  host_pixel_format_code_out
);

	//////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	localparam CMD_NONE   = 2'h0;
	localparam CMD_POWER  = 2'h1;
	localparam CMD_ORDER  = 2'h2;
	localparam CMD_PIXFMT = 2'h3;

	// idle level of every synchronised lane, so no false edge follows reset
	localparam [`DSR_SYNC_W-1:0] SYNC_IDLE = `DSR_SYNC_IDLE;

	wire [`DSR_SYNC_W-1:0] pin_raw;
	reg  [`DSR_SYNC_W-1:0] sync_a;
	reg  [`DSR_SYNC_W-1:0] sync_b;
	reg  [`DSR_SYNC_W-1:0] sync_prev;

	// upper lanes are never sampled
	assign pin_raw = {data_in[7:0], hw_reset_n_in, cmd_param_select_in, write_strobe_in,
		read_strobe_in, ser_cs_n_in, ser_clk_in, ser_data_in, serial_mode_in};

	genvar gi;
	generate
		for (gi = 0; gi < `DSR_SYNC_W; gi = gi + 1) begin : g_sync
			always @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					sync_a[gi]    <= SYNC_IDLE[gi];
					sync_b[gi]    <= SYNC_IDLE[gi];
					sync_prev[gi] <= SYNC_IDLE[gi];
				end else begin
					sync_a[gi]    <= pin_raw[gi];
					sync_b[gi]    <= sync_a[gi];
					sync_prev[gi] <= sync_b[gi];
				end
			end
		end
	endgenerate

	wire [7:0] bus_byte  = sync_b[15:8];
	wire       sel_param = sync_b[`DSR_LANE_SEL];
	wire       ser_mode  = sync_b[`DSR_LANE_MODE];
	wire       hw_rst_hit = !sync_b[`DSR_LANE_HWRST];
	wire       wr_rise   = sync_b[`DSR_LANE_WR] & ~sync_prev[`DSR_LANE_WR];
	wire       rd_rise   = sync_b[`DSR_LANE_RD] & ~sync_prev[`DSR_LANE_RD];
	wire       rd_low    = ~sync_b[`DSR_LANE_RD];
	wire       cs_active = ~sync_b[`DSR_LANE_CS];
	wire       sclk_rise = sync_b[`DSR_LANE_SCLK] & ~sync_prev[`DSR_LANE_SCLK];
	wire       sclk_fall = ~sync_b[`DSR_LANE_SCLK] & sync_prev[`DSR_LANE_SCLK];
	wire       sdin      = sync_b[`DSR_LANE_SDIN];

	//////////////////////////////////////////////////////////////////////////
	// settings held for readback

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			memory_access_control_out <= `DSR_MAC_RESET;
		end else if (hw_rst_hit) begin
			memory_access_control_out <= `DSR_MAC_RESET;
		end else if (mac_write_in) begin
			// software reset leaves this register alone
			memory_access_control_out <= mac_data_in;
		end
	end

	// power-on default equals the 18-bit code; hardware reset pin does not touch it
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			host_pixel_format_code_out <= `DSR_PIXFMT_RESET;
		end else if (sw_reset_in) begin
			host_pixel_format_code_out <= `DSR_PIXFMT_18BPP;
		end else if (pixfmt_write_in) begin
			host_pixel_format_code_out <= pixfmt_data_in;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// status bytes, built from live state

	wire [7:0] power_mode_status;
	wire [7:0] address_order_status;
	wire [7:0] pixel_format_status;

	assign power_mode_status[`DSR_PM_BOOSTER]     = booster_running_in;
	assign power_mode_status[`DSR_PM_IDLE]        = idle_active_in;
	assign power_mode_status[`DSR_PM_PARTIAL]     = partial_active_in;
	assign power_mode_status[`DSR_PM_AWAKE]       = awake_flag_in;
	assign power_mode_status[`DSR_PM_FULL_SCREEN] = full_screen_flag_in;
	assign power_mode_status[`DSR_PM_PANEL_ON]    = panel_output_on_in;
	assign power_mode_status[1:0]                 = 2'h0;

	assign address_order_status[`DSR_MAC_ROW_DIR]  = memory_access_control_out[`DSR_MAC_ROW_DIR];
	assign address_order_status[`DSR_MAC_COL_DIR]  = memory_access_control_out[`DSR_MAC_COL_DIR];
	assign address_order_status[`DSR_MAC_SWAP]     = memory_access_control_out[`DSR_MAC_SWAP];
	assign address_order_status[`DSR_MAC_VREFRESH] = memory_access_control_out[`DSR_MAC_VREFRESH];
	assign address_order_status[`DSR_MAC_BGR]      = memory_access_control_out[`DSR_MAC_BGR];
	assign address_order_status[`DSR_MAC_HREFRESH] = memory_access_control_out[`DSR_MAC_HREFRESH];
	assign address_order_status[1:0]               = 2'h0;

	// code passes through as held; the host judges 111 and undefined codes
	assign pixel_format_status = {5'h00, host_pixel_format_code_out};

	reg  [1:0] cmd;
	reg  [7:0] live_byte;

	// no capture: the byte follows state right up to the read
	always @* begin
		case (cmd)
			CMD_POWER:  live_byte = power_mode_status;
			CMD_ORDER:  live_byte = address_order_status;
			CMD_PIXFMT: live_byte = pixel_format_status;
			default:    live_byte = `DSR_DUMMY_BYTE;
		endcase
	end

	function [1:0] decode_op;
		input [7:0] op;
		begin
			case (op)
				`DSR_OP_POWER_STATE:   decode_op = CMD_POWER;
				`DSR_OP_ADDRESS_ORDER: decode_op = CMD_ORDER;
				`DSR_OP_PIXEL_FORMAT:  decode_op = CMD_PIXFMT;
				default:               decode_op = CMD_NONE;
			endcase
		end
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// parallel and serial command tracking

	reg        par_past_dummy;
	reg [7:0]  ser_shift;
	reg [2:0]  ser_bits;
	reg        ser_reading;
	reg [3:0]  ser_rcnt;

	wire [7:0] ser_opcode   = {ser_shift[6:0], sdin};
	wire       opcode_taken = wr_rise && !sel_param;
	wire       read_done    = rd_rise && sel_param && cmd != CMD_NONE;

	// first read of a readback is the dummy word; a new opcode rearms it
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			par_past_dummy <= 1'b0;
		end else if (!ser_mode) begin
			if (opcode_taken) begin
				par_past_dummy <= 1'b0;
			end else if (read_done) begin
				par_past_dummy <= 1'b1;
			end
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd         <= CMD_NONE;
			ser_shift   <= 8'h00;
			ser_bits    <= 3'h0;
			ser_reading <= 1'b0;
			ser_rcnt    <= 4'h0;
		end else if (!ser_mode) begin
			ser_reading <= 1'b0;
			ser_bits    <= 3'h0;
			if (opcode_taken) begin
				cmd <= decode_op(bus_byte);
			end
		end else if (!cs_active) begin
			ser_bits    <= 3'h0;
			ser_reading <= 1'b0;
			ser_rcnt    <= 4'h0;
		end else if (ser_reading) begin
			if (sclk_rise && ser_rcnt <= `DSR_SER_LAST_BIT) begin
				ser_rcnt <= ser_rcnt + 4'h1;
			end
		end else if (sclk_rise) begin
			ser_shift <= ser_opcode;
			ser_bits  <= ser_bits + 3'h1;
			if (ser_bits == `DSR_SER_OPCODE_LAST && !sel_param) begin
				cmd         <= decode_op(ser_opcode);
				ser_reading <= (decode_op(ser_opcode) != CMD_NONE);
				ser_rcnt    <= 4'h0;
			end
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// pin drivers

	wire       par_drive = !ser_mode && rd_low && sel_param && cmd != CMD_NONE;
	wire [3:0] ser_idx   = `DSR_SER_LAST_BIT - ser_rcnt;

	// next values of the pin registers
	reg  [7:0] next_data_out;
	reg        next_data_oe;
	reg        next_ser_data;
	reg        next_ser_oe;

	// parallel lanes: dummy word until the first read strobe has ended
	always @* begin
		next_data_oe  = par_drive;
		next_data_out = `DSR_DUMMY_BYTE;
		if (par_drive && par_past_dummy) begin
			next_data_out = live_byte;
		end
	end

	// serial lane: rising edge 0 of the read phase is the dummy clock
	always @* begin
		next_ser_oe   = ser_data_oe_out;
		next_ser_data = ser_data_out;
		if (!ser_mode || !cs_active || !ser_reading) begin
			next_ser_oe   = 1'b0;
			next_ser_data = 1'b0;
		end else if (sclk_fall) begin
			if (ser_rcnt >= `DSR_SER_FIRST_BIT && ser_rcnt <= `DSR_SER_LAST_BIT) begin
				next_ser_oe   = 1'b1;
				next_ser_data = live_byte[ser_idx[2:0]];
			end else begin
				next_ser_oe   = 1'b0;
				next_ser_data = 1'b0;
			end
		end
	end

	// every pin output comes straight from a flip-flop
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			data_out        <= 8'h00;
			data_oe_out     <= 1'b0;
			ser_data_out    <= 1'b0;
			ser_data_oe_out <= 1'b0;
		end else begin
			data_out        <= next_data_out;
			data_oe_out     <= next_data_oe;
			ser_data_out    <= next_ser_data;
			ser_data_oe_out <= next_ser_oe;
		end
	end

endmodule

// [test_display_status_readback.sv]
// self-checking bench for the status readback block
module test_display_status_readback;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in = 1'b0, rst_n_in = 1'b0, hw_reset_n_in = 1'b1, sw_reset_in = 1'b0, mac_write_in = 1'b0;
	logic pixfmt_write_in = 1'b0, booster_running_in = 1'b0, idle_active_in = 1'b0, partial_active_in = 1'b0;
	logic awake_flag_in = 1'b0, full_screen_flag_in = 1'b0, panel_output_on_in = 1'b0, o;
	logic [7:0] mac_data_in = 8'h00, d, v;
	logic [2:0] pixfmt_data_in = 3'h0;
	wire cmd_param_select_in, write_strobe_in, read_strobe_in, serial_mode_in, ser_cs_n_in, ser_clk_in, ser_data_in;
	wire data_oe_out, ser_data_out, ser_data_oe_out;
	wire [17:0] data_in;
	wire [7:0] data_out, memory_access_control_out;
	wire [2:0] host_pixel_format_code_out;
	int failures = 0, num_checks = 0, cycles = 0;
	always #12.5 clk_in = ~clk_in;
	dsr_top u_dut (.clk_in, .rst_n_in, .hw_reset_n_in, .cmd_param_select_in, .write_strobe_in, .read_strobe_in, .data_in,
		.data_out, .data_oe_out, .serial_mode_in, .ser_cs_n_in, .ser_clk_in, .ser_data_in, .ser_data_out, .ser_data_oe_out,
		.booster_running_in, .idle_active_in, .partial_active_in, .awake_flag_in, .full_screen_flag_in, .panel_output_on_in,
		.sw_reset_in, .mac_write_in, .mac_data_in, .pixfmt_write_in, .pixfmt_data_in, .memory_access_control_out,
		.host_pixel_format_code_out);
	dsr_host_model u_host (.clk_in, .rdata_in(data_out), .oe_in(data_oe_out), .sdo_in(ser_data_out),
		.sdo_oe_in(ser_data_oe_out), .sel_out(cmd_param_select_in), .wr_out(write_strobe_in), .rd_out(read_strobe_in),
		.data_out(data_in), .mode_out(serial_mode_in), .cs_n_out(ser_cs_n_in), .sclk_out(ser_clk_in), .sdin_out(ser_data_in));
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic pulse_sw_reset;
		sw_reset_in = 1'b1;
		u_host.tick(1);
		sw_reset_in = 1'b0;
		u_host.tick(1);
	endtask
	task automatic pulse_hw_reset;
		hw_reset_n_in = 1'b0;
		u_host.tick(6);
		hw_reset_n_in = 1'b1;
		u_host.tick(4);
	endtask
	// each power flag alone, then a live change without a new opcode
	task automatic t_power;
		for (int i = 0; i < 6; i++) begin
			{booster_running_in, idle_active_in, partial_active_in, awake_flag_in, full_screen_flag_in,
				panel_output_on_in} = 6'h01 << i;
			u_host.readback(8'h0A, d, v, o);
			check("dummy word", 8'h00, d);
			check("power byte", 8'h04 << i, v);
			check("drive enable", 8'h01, {7'h00, o});
		end
		panel_output_on_in = 1'b1;
		u_host.rd_par(v, o);
		check("live power byte", 8'h84, v);
	endtask
	task automatic t_address;
		check("mac at power-on", 8'h00, memory_access_control_out);
		for (int i = 0; i < 8; i++) begin
			mac_data_in = 8'h80 >> i;
			mac_write_in = 1'b1;
			u_host.tick(1);
			mac_write_in = 1'b0;
			u_host.readback(8'h0B, d, v, o);
			check("address dummy word", 8'h00, d);
			check("address byte", (8'h80 >> i) & 8'hFC, v);
		end
		mac_data_in = 8'hA4;
		mac_write_in = 1'b1;
		u_host.tick(1);
		mac_write_in = 1'b0;
		pulse_sw_reset();
		u_host.readback(8'h0B, d, v, o);
		check("address after sw reset", 8'hA4, v);
		u_host.ser_read(8'h0B, v, o);
		check("serial address byte", 8'hA4, v);
		check("serial drive enable", 8'h01, {7'h00, o});
		pulse_hw_reset();
		u_host.readback(8'h0B, d, v, o);
		check("address after hw reset", 8'h00, v);
	endtask
	// 111 is read back raw only; the host treats it as unused
	task automatic t_format;
		logic [2:0] codes[4] = '{3'h3, 3'h5, 3'h6, 3'h7};
		check("format at power-on", 8'h06, {5'h00, host_pixel_format_code_out});
		foreach (codes[i]) begin
			pixfmt_data_in = codes[i];
			pixfmt_write_in = 1'b1;
			u_host.tick(1);
			pixfmt_write_in = 1'b0;
			u_host.readback(8'h0C, d, v, o);
			check("format byte", {5'h00, codes[i]}, v);
		end
		pulse_hw_reset();
		u_host.readback(8'h0C, d, v, o);
		check("format after hw reset", 8'h07, v);
		pulse_sw_reset();
		u_host.readback(8'h0C, d, v, o);
		check("format after sw reset", 8'h06, v);
		u_host.readback(8'h09, d, v, o);
		check("drive after other opcode", 8'h00, {7'h00, o});
	endtask
	task automatic final_report;
		$display("checks %0d, failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 6000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		repeat (8) @(posedge clk_in);
		#2;
		rst_n_in = 1'b1;
		u_host.tick(4);
		t_power();
		t_address();
		t_format();
		final_report();
	end
endmodule
